// file: inc/ppoc_pkg.sv
// Shared constants and carrier types for the output pin pair control block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one clock.
package ppoc_pkg;

  // Register byte offsets on the slave port
  localparam logic [3:0] PPOC_OFS_PAIR_CTRL = 4'h0;
  localparam logic [3:0] PPOC_OFS_TIME_BASE = 4'h4;
  localparam logic [3:0] PPOC_OFS_FAULT_LIMIT = 4'h8;
  localparam logic [3:0] PPOC_OFS_STATUS = 4'hc;

  // Reset values
  localparam logic [15:0] PPOC_PAIR_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PPOC_TIME_BASE_RESET = 16'h0000;
  localparam logic [15:0] PPOC_FAULT_LIMIT_RESET = 16'h0000;

  // Single-bit field positions
  localparam int unsigned PPOC_GLOBAL_ENABLE_BIT = 15;
  localparam int unsigned PPOC_INDEP_FAULT_BIT = 15;
  localparam int unsigned PPOC_STAT_PIN_HIGH_BIT = 0;
  localparam int unsigned PPOC_STAT_PIN_LOW_BIT = 1;
  localparam int unsigned PPOC_STAT_FAULT_BIT = 2;
  localparam int unsigned PPOC_STAT_LIMIT_BIT = 3;
  localparam int unsigned PPOC_STAT_PHASE_BIT = 4;

  // Pair output modes
  typedef enum logic [1:0] {
    PPOC_MODE_COMPLEMENTARY = 2'h0,
    PPOC_MODE_REDUNDANT = 2'h1,
    PPOC_MODE_PUSH_PULL = 2'h2,
    PPOC_MODE_INDEPENDENT = 2'h3
  } ppoc_mode_type;

  // Pair control register, bit 15 first
  typedef struct packed {
    logic high_side_ownership;
    logic low_side_ownership;
    logic high_side_polarity;
    logic low_side_polarity;
    ppoc_mode_type pair_output_mode;
    logic high_side_override_enable;
    logic low_side_override_enable;
    logic [1:0] override_data;
    logic [1:0] fault_pin_data;
    logic [1:0] current_limit_pin_data;
    logic swap;
    logic override_sync;
  } ppoc_pair_ctrl_type;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } ppoc_avalon_req_type;

  // One value per pin of the pair
  typedef struct packed {
    logic high;
    logic low;
  } ppoc_pin_pair_type;

  // Protection inputs
  typedef struct packed {
    logic fault;
    logic current_limit;
  } ppoc_protect_type;

endpackage

// file: logic/ppoc_mode_mux.sv
// Maps the generator signals onto the pin pair for the selected pair mode.
// Assumes the push-pull phase toggles once per modulation period.
`timescale 1ns/1ps
module ppoc_mode_mux (
  input wire ppoc_pkg::ppoc_mode_type i_mode,
  input wire ppoc_pkg::ppoc_pin_pair_type i_pwm,
  input wire logic i_push_pull_phase,
  output ppoc_pkg::ppoc_pin_pair_type o_pair
);
  import ppoc_pkg::*;

  // All four codes are legal, so no default is needed
  always_comb begin
    unique case (i_mode)
      PPOC_MODE_COMPLEMENTARY: begin
        o_pair.high = i_pwm.high;
        o_pair.low = ~i_pwm.high;
      end
      PPOC_MODE_REDUNDANT: begin
        o_pair.high = i_pwm.high;
        o_pair.low = i_pwm.high;
      end
      PPOC_MODE_PUSH_PULL: begin
        o_pair.high = i_pwm.high & i_push_pull_phase;
        o_pair.low = i_pwm.high & ~i_push_pull_phase;
      end
      PPOC_MODE_INDEPENDENT: begin
        o_pair.high = i_pwm.high;
        o_pair.low = i_pwm.low;
      end
    endcase
  end
endmodule

// file: logic/ppoc_pin_stage.sv
// Output stage of one pin: ownership, forcing, override and polarity.
// Assumes all inputs are settled levels in the module clock domain.
`timescale 1ns/1ps
module ppoc_pin_stage (
  input wire logic i_ownership,
  input wire logic i_polarity,
  input wire logic i_override_enable,
  input wire logic i_override_data,
  input wire logic i_force,
  input wire logic i_force_data,
  input wire logic i_generator,
  input wire logic i_gpio,
  output logic o_pin_next
);
  // Forced state is the raw pin level, so polarity is not applied to it
  always_comb begin
    if (!i_ownership) begin
      o_pin_next = i_gpio;
    end else if (i_force) begin
      o_pin_next = i_force_data;
    end else if (i_override_enable) begin
      o_pin_next = i_override_data ^ i_polarity;
    end else begin
      o_pin_next = i_generator ^ i_polarity;
    end
  end
endmodule

// file: logic/ppoc_top.sv
// Output pin pair control: register file on Avalon-MM and registered pins.
// Assumes generator, GPIO and protection inputs are synchronous to i_clk.
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
module ppoc_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire ppoc_pkg::ppoc_avalon_req_type i_avalon,
  input wire ppoc_pkg::ppoc_pin_pair_type i_pwm,
  input wire ppoc_pkg::ppoc_pin_pair_type i_gpio,
  input wire ppoc_pkg::ppoc_protect_type i_protect,
  input wire logic i_period_start,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output ppoc_pkg::ppoc_pin_pair_type o_pins,
  output logic o_modulator_global_enable
);
  import ppoc_pkg::*;

  typedef struct packed {
    ppoc_pair_ctrl_type ctrl;
    logic [15:0] time_base;
    logic [15:0] fault_limit;
    logic [31:0] readdata;
    logic waitrequest;
    logic phase;
    ppoc_pin_pair_type pins;
  } ppoc_state_type;

  ppoc_state_type state_reg;
  ppoc_state_type state_next;
  ppoc_pair_ctrl_type ctrl;
  ppoc_pin_pair_type mode_pair;
  logic indep_fault;
  logic force_high;
  logic force_low;
  logic pin_high_next;
  logic pin_low_next;
  logic request;
  logic [31:0] read_value;

  assign ctrl = state_reg.ctrl;
  assign request = i_avalon.read | i_avalon.write;

  // High-side forcing source depends on the fault mode select; the low side is always forced by fault
  assign indep_fault = state_reg.fault_limit[PPOC_INDEP_FAULT_BIT];
  assign force_high = indep_fault ? i_protect.current_limit : i_protect.fault;
  assign force_low = i_protect.fault;

  ppoc_mode_mux u_mode_mux (
    .i_mode(ctrl.pair_output_mode),
    .i_pwm(i_pwm),
    .i_push_pull_phase(state_reg.phase),
    .o_pair(mode_pair)
  );

  ppoc_pin_stage u_stage_high (
    .i_ownership(ctrl.high_side_ownership),
    .i_polarity(ctrl.high_side_polarity),
    .i_override_enable(ctrl.high_side_override_enable),
    .i_override_data(ctrl.override_data[1]),
    .i_force(force_high),
    .i_force_data(ctrl.fault_pin_data[1]),
    .i_generator(mode_pair.high),
    .i_gpio(i_gpio.high),
    .o_pin_next(pin_high_next)
  );

  ppoc_pin_stage u_stage_low (
    .i_ownership(ctrl.low_side_ownership),
    .i_polarity(ctrl.low_side_polarity),
    .i_override_enable(ctrl.low_side_override_enable),
    .i_override_data(ctrl.override_data[0]),
    .i_force(force_low),
    .i_force_data(ctrl.fault_pin_data[0]),
    .i_generator(mode_pair.low),
    .i_gpio(i_gpio.low),
    .o_pin_next(pin_low_next)
  );

  // Byte-lane merge of a 16-bit register with write data
  function automatic logic [15:0] merge16(input logic [15:0] old_value,
                                          input logic [31:0] wdata,
                                          input logic [3:0] lanes);
    logic [15:0] result;
    result = old_value;
    if (lanes[0]) begin
      result[7:0] = wdata[7:0];
    end
    if (lanes[1]) begin
      result[15:8] = wdata[15:8];
    end
    return result;
  endfunction

  // Read mux; unmapped offsets read as zero
  always_comb begin
    read_value = 32'h0000_0000;
    unique case (i_avalon.address)
      PPOC_OFS_PAIR_CTRL: begin
        read_value[15:0] = state_reg.ctrl;
      end
      PPOC_OFS_TIME_BASE: begin
        read_value[15:0] = state_reg.time_base;
      end
      PPOC_OFS_FAULT_LIMIT: begin
        read_value[15:0] = state_reg.fault_limit;
      end
      PPOC_OFS_STATUS: begin
        read_value[PPOC_STAT_PIN_HIGH_BIT] = state_reg.pins.high;
        read_value[PPOC_STAT_PIN_LOW_BIT] = state_reg.pins.low;
        read_value[PPOC_STAT_FAULT_BIT] = i_protect.fault;
        read_value[PPOC_STAT_LIMIT_BIT] = i_protect.current_limit;
        read_value[PPOC_STAT_PHASE_BIT] = state_reg.phase;
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // Next state: one wait state per access, then pin update
  always_comb begin
    state_next = state_reg;
    // Answer one cycle after the request shows, then drop back to waiting
    state_next.waitrequest = !(request && state_reg.waitrequest);
    if (request && state_reg.waitrequest) begin
      state_next.readdata = i_avalon.read ? read_value : 32'h0000_0000;
    end
    // Writes land only at the edge where waitrequest is seen low
    if (i_avalon.write && !i_avalon.read && !state_reg.waitrequest) begin
      unique case (i_avalon.address)
        PPOC_OFS_PAIR_CTRL: begin
          state_next.ctrl = ppoc_pair_ctrl_type'(merge16(state_reg.ctrl,
                                                         i_avalon.writedata,
                                                         i_avalon.byteenable));
        end
        PPOC_OFS_TIME_BASE: begin
          state_next.time_base = merge16(state_reg.time_base, i_avalon.writedata,
                                         i_avalon.byteenable);
        end
        PPOC_OFS_FAULT_LIMIT: begin
          state_next.fault_limit = merge16(state_reg.fault_limit, i_avalon.writedata,
                                           i_avalon.byteenable);
        end
        default: begin
          state_next.ctrl = state_reg.ctrl;
        end
      endcase
    end
    // Push-pull alternation advances once per period
    if (i_period_start && ctrl.pair_output_mode == PPOC_MODE_PUSH_PULL) begin
      state_next.phase = ~state_reg.phase;
    end
    state_next.pins.high = pin_high_next;
    state_next.pins.low = pin_low_next;
  end

  // State register; pins come straight from flops to avoid glitches
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg.ctrl <= ppoc_pair_ctrl_type'(PPOC_PAIR_CTRL_RESET);
      state_reg.time_base <= PPOC_TIME_BASE_RESET;
      state_reg.fault_limit <= PPOC_FAULT_LIMIT_RESET;
      state_reg.readdata <= 32'h0000_0000;
      state_reg.waitrequest <= 1'b1;
      state_reg.phase <= 1'b0;
      state_reg.pins <= 2'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_readdata = state_reg.readdata;
  assign o_waitrequest = state_reg.waitrequest;
  assign o_pins = state_reg.pins;
  assign o_modulator_global_enable = state_reg.time_base[PPOC_GLOBAL_ENABLE_BIT];

  // Checks of the pin behaviour and the bus answer
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  property p_high_gpio;
    !ctrl.high_side_ownership |=> o_pins.high == $past(i_gpio.high);
  endproperty
  a_high_gpio: assert property (p_high_gpio) else $error("high pin not from gpio");

  property p_low_gpio;
    !ctrl.low_side_ownership |=> o_pins.low == $past(i_gpio.low);
  endproperty
  a_low_gpio: assert property (p_low_gpio) else $error("low pin not from gpio");

  property p_high_polarity;
    ctrl.high_side_ownership && !force_high && !ctrl.high_side_override_enable &&
      ctrl.pair_output_mode != PPOC_MODE_PUSH_PULL
      |=> o_pins.high == ($past(i_pwm.high) ^ $past(ctrl.high_side_polarity));
  endproperty
  a_high_polarity: assert property (p_high_polarity) else $error("high polarity wrong");

  property p_low_independent;
    ctrl.low_side_ownership && !force_low && !ctrl.low_side_override_enable &&
      ctrl.pair_output_mode == PPOC_MODE_INDEPENDENT
      |=> o_pins.low == ($past(i_pwm.low) ^ $past(ctrl.low_side_polarity));
  endproperty
  a_low_independent: assert property (p_low_independent) else $error("low independent wrong");

  property p_push_pull;
    ctrl.high_side_ownership && ctrl.low_side_ownership && !force_high && !force_low &&
      !ctrl.high_side_override_enable && !ctrl.low_side_override_enable &&
      !ctrl.high_side_polarity && !ctrl.low_side_polarity &&
      ctrl.pair_output_mode == PPOC_MODE_PUSH_PULL
      |=> !(o_pins.high && o_pins.low) &&
          o_pins.high == ($past(i_pwm.high) & $past(state_reg.phase));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pins overlap");

  property p_phase_toggle;
    i_period_start && ctrl.pair_output_mode == PPOC_MODE_PUSH_PULL
      |=> state_reg.phase != $past(state_reg.phase);
  endproperty
  a_phase_toggle: assert property (p_phase_toggle) else $error("phase did not toggle");

  property p_complementary;
    ctrl.low_side_ownership && !force_low && !ctrl.low_side_override_enable &&
      ctrl.pair_output_mode == PPOC_MODE_COMPLEMENTARY
      |=> o_pins.low == (~$past(i_pwm.high) ^ $past(ctrl.low_side_polarity));
  endproperty
  a_complementary: assert property (p_complementary) else $error("low not inverse");

  property p_redundant;
    ctrl.low_side_ownership && !force_low && !ctrl.low_side_override_enable &&
      ctrl.pair_output_mode == PPOC_MODE_REDUNDANT
      |=> o_pins.low == ($past(i_pwm.high) ^ $past(ctrl.low_side_polarity));
  endproperty
  a_redundant: assert property (p_redundant) else $error("low not same as high");

  property p_override_high;
    ctrl.high_side_ownership && ctrl.high_side_override_enable && !force_high
      |=> o_pins.high == ($past(ctrl.override_data[1]) ^ $past(ctrl.high_side_polarity));
  endproperty
  a_override_high: assert property (p_override_high) else $error("high override wrong");

  property p_override_low;
    ctrl.low_side_ownership && ctrl.low_side_override_enable && !force_low
      |=> o_pins.low == ($past(ctrl.override_data[0]) ^ $past(ctrl.low_side_polarity));
  endproperty
  a_override_low: assert property (p_override_low) else $error("low override wrong");

  property p_override_data_split;
    ctrl.high_side_ownership && ctrl.low_side_ownership && !indep_fault &&
      !i_protect.fault && ctrl.high_side_override_enable && ctrl.low_side_override_enable &&
      !ctrl.high_side_polarity && !ctrl.low_side_polarity
      |=> o_pins == $past(ctrl.override_data);
  endproperty
  a_override_data_split: assert property (p_override_data_split) else $error("override split");

  property p_fault_normal;
    ctrl.high_side_ownership && ctrl.low_side_ownership && !indep_fault && i_protect.fault
      |=> o_pins == $past(ctrl.fault_pin_data);
  endproperty
  a_fault_normal: assert property (p_fault_normal) else $error("fault state wrong");

  property p_limit_independent;
    ctrl.high_side_ownership && indep_fault && i_protect.current_limit
      |=> o_pins.high == $past(ctrl.fault_pin_data[1]);
  endproperty
  a_limit_independent: assert property (p_limit_independent) else $error("limit state");

  property p_fault_independent;
    ctrl.low_side_ownership && indep_fault && i_protect.fault
      |=> o_pins.low == $past(ctrl.fault_pin_data[0]);
  endproperty
  a_fault_independent: assert property (p_fault_independent) else $error("low fault");

  property p_phase_hold;
    ctrl.pair_output_mode != PPOC_MODE_PUSH_PULL
      |=> state_reg.phase == $past(state_reg.phase);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase moved");

  property p_global_enable;
    i_avalon.write && !i_avalon.read && !o_waitrequest &&
      i_avalon.address == PPOC_OFS_TIME_BASE && i_avalon.byteenable[1]
      |=> o_modulator_global_enable == $past(i_avalon.writedata[15]);
  endproperty
  a_global_enable: assert property (p_global_enable) else $error("enable not written");

  property p_bus_answer;
    (i_avalon.read || i_avalon.write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");
endmodule

// file: verif/ppoc_switch_model.sv
// Behavioural model of the power switch pair hung on the output pins.
// Assumes gates are driven high to conduct and switch instantly.
`timescale 1ns/1ps
module ppoc_switch_model (
  input wire ppoc_pkg::ppoc_pin_pair_type i_pins,
  output ppoc_pkg::ppoc_pin_pair_type o_conduct,
  output logic o_shoot_through
);
  import ppoc_pkg::*;

  // No switching delay, so any overlap at the pins shows at once
  assign o_conduct = i_pins;
  assign o_shoot_through = i_pins.high & i_pins.low;
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the output pin pair control block.
// Assumes the switch model beside it and one 125 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import ppoc_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  ppoc_avalon_req_type req = '0;
  ppoc_pin_pair_type pwm = '0;
  ppoc_pin_pair_type gpio = '0;
  ppoc_protect_type prot = '0;
  logic period_start = 1'b0;
  logic [31:0] rdata;
  logic wait_req;
  ppoc_pin_pair_type pins;
  ppoc_pin_pair_type conduct;
  logic glob_en;
  logic shoot;
  logic ph = 1'b0;
  logic [31:0] q;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  ppoc_top u_ppoc_top (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_avalon(req),
    .i_pwm(pwm),
    .i_gpio(gpio),
    .i_protect(prot),
    .i_period_start(period_start),
    .o_readdata(rdata),
    .o_waitrequest(wait_req),
    .o_pins(pins),
    .o_modulator_global_enable(glob_en)
  );

  ppoc_switch_model u_ppoc_switch_model (
    .i_pins(pins),
    .o_conduct(conduct),
    .o_shoot_through(shoot)
  );

  // Free-running 8 ns clock
  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic pchk(input logic [1:0] exp);
    chk({30'h0, conduct}, {30'h0, exp});
  endtask

  // One Avalon access; waitrequest is read at each rising edge before the
  // design updates it, so the bench sees what that edge samples
  // A stuck slave is caught by the hang guard, not here
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge i_clk);
    req.read <= rd;
    req.write <= ~rd;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= be;
    @(posedge i_clk);
    while (wait_req !== 1'b0) begin
      @(posedge i_clk);
    end
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 4'hf);
  endtask

  task automatic rd(input logic [3:0] a);
    bus(1'b1, a, 32'h0, 4'hf);
  endtask

  // Pin inputs change at an edge; pins are looked at two edges later
  task automatic pins_at(input logic [1:0] w, input logic [1:0] g, input logic [1:0] pr);
    @(posedge i_clk);
    pwm <= w;
    gpio <= g;
    prot <= pr;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic pulse();
    @(posedge i_clk);
    period_start <= 1'b1;
    @(posedge i_clk);
    period_start <= 1'b0;
  endtask

  // Expected pair before polarity, from mode, phase and generator inputs
  function automatic logic [1:0] exp_mode(input logic [1:0] m, input logic p,
                                          input logic [1:0] w);
    case (m)
      2'h0: return {w[1], ~w[1]};
      2'h1: return {w[1], w[1]};
      2'h2: return {w[1] & p, w[1] & ~p};
      default: return w;
    endcase
  endfunction

  // Main sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(PPOC_OFS_PAIR_CTRL);
    chk(q, {16'h0, PPOC_PAIR_CTRL_RESET});
    rd(PPOC_OFS_TIME_BASE);
    chk(q, {16'h0, PPOC_TIME_BASE_RESET});
    rd(PPOC_OFS_FAULT_LIMIT);
    chk(q, {16'h0, PPOC_FAULT_LIMIT_RESET});
    // Ownership: GPIO, then each side alone taken by the modulator
    pins_at(2'b10, 2'b01, 2'b00);
    pchk(2'b01);
    wr(PPOC_OFS_PAIR_CTRL, 32'h8000);
    pins_at(2'b10, 2'b01, 2'b00);
    pchk(2'b11);
    wr(PPOC_OFS_PAIR_CTRL, 32'h4000);
    pins_at(2'b10, 2'b01, 2'b00);
    pchk(2'b00);
    // Every mode and polarity pair; phase only moves in push-pull
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 4; p++) begin
        wr(PPOC_OFS_PAIR_CTRL, 32'hc000 | (p << 12) | (m << 10));
        pulse();
        if (m == 2) begin
          ph = ~ph;
        end
        for (int w = 0; w < 4; w++) begin
          pins_at(w[1:0], 2'b00, 2'b00);
          pchk(exp_mode(m[1:0], ph, w[1:0]) ^ p[1:0]);
          if (m == 0 && p == 0) begin
            chk({31'h0, shoot}, 32'h0);
          end
        end
      end
    end
    // Override data through polarity, both sides then one side each
    for (int d = 0; d < 4; d++) begin
      wr(PPOC_OFS_PAIR_CTRL, 32'he300 | (d << 6));
      pins_at(2'b11, 2'b00, 2'b00);
      pchk({~d[1], d[0]});
    end
    wr(PPOC_OFS_PAIR_CTRL, 32'hc380);
    pins_at(2'b01, 2'b00, 2'b00);
    pchk(2'b10);
    wr(PPOC_OFS_PAIR_CTRL, 32'hc280);
    pins_at(2'b00, 2'b00, 2'b00);
    pchk(2'b11);
    wr(PPOC_OFS_PAIR_CTRL, 32'hc140);
    pins_at(2'b10, 2'b00, 2'b00);
    pchk(2'b11);
    // Normal fault mode: fault data raw, limit ignored
    for (int f = 0; f < 4; f++) begin
      wr(PPOC_OFS_PAIR_CTRL, 32'hf000 | (f << 4) | ((~f & 3) << 2));
      pins_at(2'b10, 2'b00, 2'b10);
      pchk(f[1:0]);
    end
    pins_at(2'b10, 2'b00, 2'b01);
    pchk(2'b01);
    // Independent fault mode: limit owns high, fault owns low
    wr(PPOC_OFS_FAULT_LIMIT, 32'h8000);
    wr(PPOC_OFS_PAIR_CTRL, 32'hc010);
    pins_at(2'b10, 2'b00, 2'b01);
    pchk(2'b00);
    pins_at(2'b10, 2'b00, 2'b10);
    pchk(2'b11);
    pins_at(2'b10, 2'b00, 2'b11);
    pchk(2'b01);
    // Readback, byte lanes, unmapped and read-only places
    wr(PPOC_OFS_PAIR_CTRL, 32'hffff_a5c3);
    rd(PPOC_OFS_PAIR_CTRL);
    chk(q, 32'h0000_a5c3);
    bus(1'b0, PPOC_OFS_PAIR_CTRL, 32'h0000_bb3c, 4'h1);
    rd(PPOC_OFS_PAIR_CTRL);
    chk(q, 32'h0000_a53c);
    wr(4'h2, 32'h1234);
    rd(4'h2);
    chk(q, 32'h0);
    wr(PPOC_OFS_PAIR_CTRL, 32'h0);
    wr(PPOC_OFS_STATUS, 32'hffff);
    pins_at(2'b00, 2'b10, 2'b10);
    rd(PPOC_OFS_STATUS);
    chk(q, {27'h0, ph, 4'b0101});
    // Global enable only after the mode is settled
    wr(PPOC_OFS_TIME_BASE, 32'h8000);
    pins_at(2'b00, 2'b10, 2'b00);
    chk({31'h0, glob_en}, 32'h1);
    rd(PPOC_OFS_TIME_BASE);
    chk(q, 32'h8000);
    close_out();
  end
endmodule
